// *** bench/dcf_bus_model.sv ***
// Reader-side model of the three-state data output bus
`timescale 1ns/1ns
module dcf_bus_model (
   // Clock
   input wire logic clk,
   // Device side
   input wire logic [dcf_pkg::DATA_W-1:0] q_drv,
   input wire logic q_oe,
   // Reader side
   output logic [dcf_pkg::DATA_W-1:0] q_bus
);
   import dcf_pkg::*;
   logic [DATA_W-1:0] last_q = '0;
   // A released bus flips every cycle, so a stale word never passes
   always @(posedge clk) begin
      last_q <= q_oe ? q_drv : ~last_q;
   end
   // Drive only while the device enables its outputs
   assign q_bus = q_oe ? q_drv : ~last_q;
endmodule // dcf_bus_model

// *** bench/dcf_fifo_bench.sv ***
// Self-checking bench for the FIFO with offset flags
`timescale 1ns/1ns
module dcf_fifo_bench;
   import dcf_pkg::*;
   // Small depth keeps fill and drain short
   localparam int DEPTH = 8;
   logic clk;
   logic sys_rst;
   logic [DATA_W-1:0] wdata;
   logic wen_n;
   logic pin;
   logic ra_n;
   logic rb_n;
   logic oe_n;
   logic [DATA_W-1:0] rdata;
   logic rdata_oe;
   logic [DATA_W-1:0] bus_q;
   dcf_flags_t flags;
   int err_count;
   int tests_run;
   int q[$];
   int ofs[4];
   int sel;
   int mode;
   int exp_rd;
   int i;
   logic [DATA_W-1:0] v;

   dcf_fifo #(.DEPTH(DEPTH)) dcf_fifo_i (
      .CLK(clk), .SYS_RST(sys_rst), .WRITE_DATA(wdata),
      .WRITE_ENABLE_PRIMARY_N(wen_n), .WRITE_ENABLE_SECONDARY_OR_LOAD(pin),
      .READ_ENABLE_A_N(ra_n), .READ_ENABLE_B_N(rb_n),
      .OUTPUT_ENABLE_N(oe_n), .READ_DATA(rdata), .READ_DATA_OE(rdata_oe),
      .STATUS_FLAGS(flags)
   );
   dcf_bus_model dcf_bus_model_i (
      .clk(clk), .q_drv(rdata), .q_oe(rdata_oe), .q_bus(bus_q)
   );

   // Write and read sides share one clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************
   // Checking helpers
   // ****************************
   task automatic stop_test();
      $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic expect_eq(logic [8:0] got, logic [8:0] exp, string what);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Flags follow the stored count, thresholds trimmed to address width
   task automatic check_all();
      int n;
      int ne;
      int mf;
      dcf_flags_t ef;
      n = q.size();
      ne = ((ofs[1] << 8) | ofs[0]) % DEPTH;
      mf = ((ofs[3] << 8) | ofs[2]) % DEPTH;
      ef.full_n = (n != DEPTH);
      ef.almost_full_n = !(n >= DEPTH - mf);
      ef.almost_empty_n = !(n <= ne);
      ef.empty_n = (n != 0);
      expect_eq(9'(flags), 9'(ef), "flags");
      expect_eq(rdata, 9'(exp_rd), "output register");
      expect_eq(9'(rdata_oe), 9'(!oe_n), "output enable");
      if (!oe_n) expect_eq(bus_q, 9'(exp_rd), "bus");
   endtask

   // ****************************
   // Drivers and reference model
   // ****************************
   // One edge of stimulus; the model applies what that edge takes
   task automatic step(logic w, logic p, logic a, logic b, logic [8:0] d);
      int n;
      {wen_n, pin, ra_n, rb_n, wdata} <= {w, p, a, b, d};
      @(posedge clk);
      n = q.size();
      if (mode == 0 && p == 1'b0) begin
         if (w == 1'b0) begin
            ofs[sel] = d[7:0];
            sel = (sel + 1) % 4;
         end else if (a == 1'b0 && b == 1'b0) begin
            exp_rd = ofs[sel];
            sel = (sel + 1) % 4;
         end
      end else begin
         if (w == 1'b0 && p == 1'b1 && n < DEPTH) q.push_back(d);
         if (a == 1'b0 && b == 1'b0 && n > 0) exp_rd = q.pop_front();
      end
   endtask

   // Idle with the load pin high, let the flags land, then compare
   task automatic settle();
      {wen_n, pin, ra_n, rb_n} <= 4'hf;
      oe_n <= 1'($urandom);
      repeat (3) @(posedge clk);
      #1;
      check_all();
      // Hand back on an edge so the next drive lands on it
      @(posedge clk);
   endtask

   // Reset at the start and again in mid-run; the pin level picks the mode
   task automatic do_reset(logic m);
      sys_rst <= 1'b1;
      pin <= m;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      pin <= 1'b1;
      q.delete();
      ofs = '{7, 0, 7, 0};
      sel = 0;
      mode = m;
      exp_rd = 0;
      @(posedge clk);
      #1;
      check_all();
      @(posedge clk);
   endtask

   task automatic rand_ops(int cnt, logic dual);
      logic [3:0] e;
      logic [8:0] d;
      for (int k = 0; k < cnt; k++) begin
         e = 4'($urandom);
         d = 9'($urandom);
         step(e[3], dual ? e[2] : 1'b1, e[1], e[0], d);
         settle();
      end
   endtask

   // Back-to-back writes past full, then drain one past empty
   task automatic fill_drain();
      for (int k = 0; k < DEPTH + 2; k++) begin
         step(1'b0, 1'b1, 1'b1, 1'b1, 9'($urandom));
      end
      settle();
      for (int k = 0; k <= DEPTH; k++) begin
         step(1'b1, 1'b1, 1'b0, 1'b0, 9'h000);
         settle();
      end
   endtask

   // ****************************
   // Test sequence
   // ****************************
   initial begin
      {sys_rst, wen_n, pin, ra_n, rb_n, oe_n, wdata} = '1;
      err_count = 0;
      tests_run = 0;
      void'($urandom(32'h56c86485));
      do_reset(1'b0);
      $display("T1 reset values done");
      // Offsets are never read and written in one cycle
      for (i = 0; i < 4; i++) begin
         step(1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
         settle();
      end
      for (i = 0; i < 4; i++) begin
         v = (i % 2) ? 9'h000 : 9'(2 + i / 2);
         step(1'b0, 1'b0, 1'b1, 1'b1, v);
         settle();
      end
      for (i = 0; i < 4; i++) begin
         step(1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
         settle();
      end
      $display("T2 offset registers done");
      fill_drain();
      rand_ops(60, 1'b0);
      $display("T3 flag mode traffic done");
      // Second reset in mid-run switches to dual enable mode
      do_reset(1'b1);
      rand_ops(60, 1'b1);
      fill_drain();
      $display("T4 dual enable mode done");
      stop_test();
   end

   // Whole run needs about 800 cycles
   initial begin
      #100000;
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test();
   end
endmodule // dcf_fifo_bench

// *** logic/dcf_fifo.sv ***
// FIFO with full, empty and programmable almost flags on one clock
`timescale 1ns/1ns

// ***************************************************
// Two-entry buffer
// ***************************************************
module dcf_skid_buf #(
   parameter int W = 9,
   parameter int N = 2
) (
   // Clock and reset
   input logic clk,
   input logic rst,
   // Filling side
   input logic in_valid,
   output logic in_ready,
   input logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (N > 1) ? $clog2(N) : 1;
   localparam int CW = $clog2(N + 1);
   logic [W-1:0] mem_reg [N];
   logic [PW-1:0] wp_reg;
   logic [PW-1:0] rp_reg;
   logic [CW-1:0] cnt_reg;
   logic push;
   logic pop;

   // Handshake terms straight from the count
   assign in_ready = cnt_reg != CW'(N);
   assign out_valid = cnt_reg != '0;
   assign out_data = mem_reg[rp_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage needs no reset; count guards it
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data;
      end
   end

   // Pointers wrap at N so any depth works
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == PW'(N - 1)) ? '0 : wp_reg + 1'h1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == PW'(N - 1)) ? '0 : rp_reg + 1'h1;
         end
      end
   end

   // Occupancy
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else if (push && !pop) begin
         cnt_reg <= cnt_reg + 1'h1;
      end else if (pop && !push) begin
         cnt_reg <= cnt_reg - 1'h1;
      end
   end
endmodule // dcf_skid_buf

// ***************************************************
// Top level
// ***************************************************
module dcf_fifo #(
   parameter int DEPTH = dcf_pkg::DEPTH_DEF
) (
   // Clock and reset
   input logic CLK,
   input logic SYS_RST,
   // Write port
   input logic [dcf_pkg::DATA_W-1:0] WRITE_DATA,
   input logic WRITE_ENABLE_PRIMARY_N,
   input logic WRITE_ENABLE_SECONDARY_OR_LOAD,
   // Read port
   input logic READ_ENABLE_A_N,
   input logic READ_ENABLE_B_N,
   input logic OUTPUT_ENABLE_N,
   output logic [dcf_pkg::DATA_W-1:0] READ_DATA,
   output logic READ_DATA_OE,
   // Status
   output dcf_pkg::dcf_flags_t STATUS_FLAGS
);
   import dcf_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

   logic [DATA_W-1:0] store_reg [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [CW-1:0] mem_cnt_reg;
   logic [CW-1:0] total_reg;
   logic [CW-1:0] total_next;
   logic mode_dual_reg;
   dcf_ofs_sel_t ofs_sel_reg;
   dcf_ofs_sel_t ofs_sel_next;
   dcf_offsets_t ofs_reg;
   dcf_flags_t flags_reg;
   logic [DATA_W-1:0] out_reg;
   logic [OFS_BYTE_W-1:0] ofs_byte;
   logic [15:0] empty_word;
   logic [15:0] full_word;
   logic [CW-1:0] n_ofs;
   logic [CW-1:0] af_thr;
   logic offset_load_n;
   logic load_active;
   logic wr_req;
   logic rd_req;
   logic fifo_wr;
   logic ofs_wr;
   logic ofs_rd;
   logic mem_pop;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic buf_pop;
   logic [DATA_W-1:0] buf_out_data;

   // ***************************************************
   // Request decode
   // ***************************************************
   // Second pin doubles as load control in flag mode
   assign offset_load_n = WRITE_ENABLE_SECONDARY_OR_LOAD;
   assign load_active = !mode_dual_reg && !offset_load_n;
   // Both modes need the pin high for a data write
   assign wr_req = !WRITE_ENABLE_PRIMARY_N
      && WRITE_ENABLE_SECONDARY_OR_LOAD;
   assign fifo_wr = wr_req && flags_reg.full_n;
   assign rd_req = !READ_ENABLE_A_N && !READ_ENABLE_B_N;
   assign ofs_wr = load_active && !WRITE_ENABLE_PRIMARY_N;
   // Write wins if both arrive; the read is dropped
   assign ofs_rd = load_active && rd_req && !ofs_wr;
   assign buf_out_ready = rd_req && !load_active;
   assign buf_pop = buf_out_valid && buf_out_ready;
   assign mem_pop = (mem_cnt_reg != '0) && buf_in_ready;

   // Mode is caught on every reset cycle, held after
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mode_dual_reg <= WRITE_ENABLE_SECONDARY_OR_LOAD;
      end
   end

   // ***************************************************
   // Storage and pointers
   // ***************************************************
   // Power-of-two depth lets the pointers wrap freely
   always_ff @(posedge CLK) begin
      if (fifo_wr) begin
         store_reg[wp_reg] <= WRITE_DATA;
      end
   end

   // Both pointers share CLK, so no crossing is needed
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         if (fifo_wr) begin
            wp_reg <= wp_reg + 1'h1;
         end
         if (mem_pop) begin
            rp_reg <= rp_reg + 1'h1;
         end
      end
   end

   // Words still in storage, not yet in the buffer
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mem_cnt_reg <= '0;
      end else if (fifo_wr && !mem_pop) begin
         mem_cnt_reg <= mem_cnt_reg + 1'h1;
      end else if (mem_pop && !fifo_wr) begin
         mem_cnt_reg <= mem_cnt_reg - 1'h1;
      end
   end

   // Buffer ready stalls the prefetch, so no word drops
   dcf_skid_buf #(
      .W(DATA_W),
      .N(BUF_DEPTH)
   ) u_buf (
      .clk(CLK),
      .rst(SYS_RST),
      .in_valid(mem_pop),
      .in_ready(buf_in_ready),
      .in_data(store_reg[rp_reg]),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // ***************************************************
   // Word count and flags
   // ***************************************************
   // Count covers storage and buffer together
   always_comb begin
      total_next = total_reg;
      if (fifo_wr && !buf_pop) begin
         total_next = total_reg + 1'h1;
      end else if (buf_pop && !fifo_wr) begin
         total_next = total_reg - 1'h1;
      end
   end

   // Offsets trimmed to the address width of DEPTH
   assign empty_word = {ofs_reg.empty_hi, ofs_reg.empty_lo};
   assign full_word = {ofs_reg.full_hi, ofs_reg.full_lo};
   assign n_ofs = {1'h0, empty_word[AW-1:0]};
   assign af_thr = DEPTH_C - {1'h0, full_word[AW-1:0]};

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         total_reg <= '0;
      end else begin
         total_reg <= total_next;
      end
   end

   // Flags registered on the same edge as the access
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         flags_reg <= FLAGS_RST;
      end else begin
         flags_reg.full_n <= total_next != DEPTH_C;
         flags_reg.almost_full_n <= total_next < af_thr;
         flags_reg.almost_empty_n <= total_next > n_ofs;
         flags_reg.empty_n <= total_next != '0;
      end
   end

   // Empty follows the buffer: a word is readable only there
   assign STATUS_FLAGS = {flags_reg.full_n, flags_reg.almost_full_n,
      flags_reg.almost_empty_n, buf_out_valid};

   // ***************************************************
   // Offset registers
   // ***************************************************
   always_comb begin
      case (ofs_sel_reg)
         SEL_EMPTY_LO: ofs_sel_next = SEL_EMPTY_HI;
         SEL_EMPTY_HI: ofs_sel_next = SEL_FULL_LO;
         SEL_FULL_LO: ofs_sel_next = SEL_FULL_HI;
         default: ofs_sel_next = SEL_EMPTY_LO;
      endcase
   end

   // Position survives the load pin going high
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ofs_sel_reg <= SEL_EMPTY_LO;
      end else if (ofs_wr || ofs_rd) begin
         ofs_sel_reg <= ofs_sel_next;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ofs_reg <= OFS_RST;
      end else if (ofs_wr) begin
         case (ofs_sel_reg)
            SEL_EMPTY_LO: ofs_reg.empty_lo <= WRITE_DATA[7:0];
            SEL_EMPTY_HI: ofs_reg.empty_hi <= WRITE_DATA[7:0];
            SEL_FULL_LO: ofs_reg.full_lo <= WRITE_DATA[7:0];
            default: ofs_reg.full_hi <= WRITE_DATA[7:0];
         endcase
      end
   end

   always_comb begin
      case (ofs_sel_reg)
         SEL_EMPTY_LO: ofs_byte = ofs_reg.empty_lo;
         SEL_EMPTY_HI: ofs_byte = ofs_reg.empty_hi;
         SEL_FULL_LO: ofs_byte = ofs_reg.full_lo;
         default: ofs_byte = ofs_reg.full_hi;
      endcase
   end

   // ***************************************************
   // Output register and bus
   // ***************************************************
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         out_reg <= OUT_RST;
      end else if (ofs_rd) begin
         out_reg <= {1'h0, ofs_byte};
      end else if (buf_pop) begin
         out_reg <= buf_out_data;
      end
   end

   // Pin driver resolves the wire from the enable
   assign READ_DATA = out_reg;
   assign READ_DATA_OE = !OUTPUT_ENABLE_N;

   // ***************************************************
   // Assertions
   // ***************************************************
   property p_reset_flags;
      @(posedge CLK) SYS_RST |=> STATUS_FLAGS == FLAGS_RST;
   endproperty
   a_reset_flags: assert property (p_reset_flags)
      else $error("flags wrong after reset");

   property p_reset_ptr;
      @(posedge CLK) SYS_RST |=> wp_reg == '0 && rp_reg == '0
         && total_reg == '0;
   endproperty
   a_reset_ptr: assert property (p_reset_ptr)
      else $error("pointers not cleared by reset");

   property p_reset_regs;
      @(posedge CLK) SYS_RST |=> out_reg == OUT_RST && ofs_reg == OFS_RST;
   endproperty
   a_reset_regs: assert property (p_reset_regs)
      else $error("output or offsets not restored");

   property p_full_block;
      @(posedge CLK) disable iff (SYS_RST)
      (!STATUS_FLAGS.full_n && !buf_pop) |=> $stable(total_reg);
   endproperty
   a_full_block: assert property (p_full_block)
      else $error("write taken while full");

   property p_full_depth;
      @(posedge CLK) disable iff (SYS_RST)
      STATUS_FLAGS.full_n == (total_reg != DEPTH_C);
   endproperty
   a_full_depth: assert property (p_full_depth)
      else $error("full flag disagrees with count");

   property p_empty_hold;
      @(posedge CLK) disable iff (SYS_RST)
      (!STATUS_FLAGS.empty_n && !ofs_rd) |=> $stable(out_reg);
   endproperty
   a_empty_hold: assert property (p_empty_hold)
      else $error("read taken while empty");

   property p_read_move;
      @(posedge CLK) disable iff (SYS_RST)
      buf_pop |=> out_reg == $past(buf_out_data);
   endproperty
   a_read_move: assert property (p_read_move)
      else $error("read did not load output");

   property p_almost_empty;
      @(posedge CLK) disable iff (SYS_RST)
      ##1 STATUS_FLAGS.almost_empty_n == (total_reg > $past(n_ofs));
   endproperty
   a_almost_empty: assert property (p_almost_empty)
      else $error("almost-empty flag wrong");

   property p_almost_full;
      @(posedge CLK) disable iff (SYS_RST)
      ##1 STATUS_FLAGS.almost_full_n == (total_reg < $past(af_thr));
   endproperty
   a_almost_full: assert property (p_almost_full)
      else $error("almost-full flag wrong");

   property p_ofs_wrap;
      @(posedge CLK) disable iff (SYS_RST)
      (ofs_wr && ofs_sel_reg == SEL_FULL_HI) |=> ofs_sel_reg == SEL_EMPTY_LO;
   endproperty
   a_ofs_wrap: assert property (p_ofs_wrap)
      else $error("offset sequence did not wrap");

   property p_dual_gate;
      @(posedge CLK) disable iff (SYS_RST)
      (mode_dual_reg && !WRITE_ENABLE_SECONDARY_OR_LOAD) |=>
         wp_reg == $past(wp_reg);
   endproperty
   a_dual_gate: assert property (p_dual_gate)
      else $error("write with second enable low");

   // A zero count must never show a readable word
   property p_empty_count;
      @(posedge CLK) disable iff (SYS_RST)
      !flags_reg.empty_n |-> !STATUS_FLAGS.empty_n;
   endproperty
   a_empty_count: assert property (p_empty_count)
      else $error("empty flag high with no words stored");
endmodule // dcf_fifo

// *** logic/dcf_pkg.sv ***
// Shared constants and types for the dual-port FIFO with offset flags
package dcf_pkg;

   // ***************************************************
   // Widths and sizes
   // ***************************************************
   localparam int DATA_W = 9;
   localparam int OFS_BYTE_W = 8;
   localparam int DEPTH_DEF = 64;
   localparam int BUF_DEPTH = 2;

   // ***************************************************
   // Values after reset
   // ***************************************************
   localparam logic [OFS_BYTE_W-1:0] OFS_LO_RST = 8'h07;
   localparam logic [OFS_BYTE_W-1:0] OFS_HI_RST = 8'h00;
   localparam logic [DATA_W-1:0] OUT_RST = 9'h000;
   localparam logic MODE_RST = 1'h0;

   // ***************************************************
   // Offset register sequence
   // ***************************************************
   typedef enum logic [1:0] {
      SEL_EMPTY_LO = 2'h0,
      SEL_EMPTY_HI = 2'h1,
      SEL_FULL_LO = 2'h2,
      SEL_FULL_HI = 2'h3
   } dcf_ofs_sel_t;

   // ***************************************************
   // Carriers
   // ***************************************************
   typedef struct packed {
      logic full_n;
      logic almost_full_n;
      logic almost_empty_n;
      logic empty_n;
   } dcf_flags_t;

   typedef struct packed {
      logic [OFS_BYTE_W-1:0] empty_lo;
      logic [OFS_BYTE_W-1:0] empty_hi;
      logic [OFS_BYTE_W-1:0] full_lo;
      logic [OFS_BYTE_W-1:0] full_hi;
   } dcf_offsets_t;

   localparam dcf_flags_t FLAGS_RST = 4'hc;
   localparam dcf_offsets_t OFS_RST =
      {OFS_LO_RST, OFS_HI_RST, OFS_LO_RST, OFS_HI_RST};

endpackage
